// ---- hw/stlb_pkg.sv ----
// Package for the split translation buffers: widths, field positions, reset values.
// Assumes big-endian bit numbering of the effective address (bit 0 is the MSB).
package stlb_pkg;
  localparam int STLB_EA_W = 32;
  localparam int STLB_SETS = 64;
  localparam int STLB_WAYS = 2;
  localparam int STLB_IDX_W = 6;
  localparam int STLB_SEG_N = 16;
  localparam int STLB_VIRTUAL_SEGMENT_ID_W = 24;
  localparam int STLB_EPI_W = 4;
  localparam int STLB_API_W = 6;
  localparam int STLB_RPN_W = 20;
  localparam int STLB_ATTR_W = 4;
  localparam int STLB_PP_W = 2;
  // Little-endian positions of big-endian EA fields
  localparam int STLB_SR_LSB = 28;
  localparam int STLB_API_LSB = 22;
  localparam int STLB_EPI_LSB = 18;
  localparam int STLB_IDX_LSB = 12;
  // Entry layout: valid, virtual_segment_id, api, epi, rpn, attr, pp, changed
  localparam int STLB_TAG_W = STLB_VIRTUAL_SEGMENT_ID_W + STLB_API_W + STLB_EPI_W;
  localparam int STLB_ENT_W = 1 + STLB_TAG_W + STLB_RPN_W + STLB_ATTR_W + STLB_PP_W + 1;
  localparam int STLB_E_C = 0;
  localparam int STLB_E_PP = 1;
  localparam int STLB_E_ATTR = 3;
  localparam int STLB_E_RPN = 7;
  localparam int STLB_E_TAG = 27;
  localparam int STLB_E_V = STLB_ENT_W - 1;
  localparam logic STLB_XLATE_RST = 1'b0;
  localparam logic [STLB_VIRTUAL_SEGMENT_ID_W-1:0] STLB_SR_RST = 24'h000000;
  localparam logic [STLB_IDX_W-1:0] STLB_LRU_RST = 6'h00;
  typedef enum logic [2:0] {
    STLB_EXC_NONE = 3'h1,
    STLB_EXC_IMISS = 3'h2,
    STLB_EXC_DMISS = 3'h4
  } stlb_exc_t;
endpackage

// ---- hw/stlb_mem.sv ----
// Entry array for one translation buffer, both ways of a set per word.
// Assumes write and read on the same clock; read data come out of a register.
`timescale 1ns/1ps
module stlb_mem
  import stlb_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int W = 2 * STLB_ENT_W
) (
  input wire logic i_clk_sys,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [W-1:0] i_wmask
);
  logic [W-1:0] mem_q [DEPTH];

  // No reset on the array: valid bits survive reset
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_q[i_waddr] <= (mem_q[i_waddr] & ~i_wmask) | (i_wdata & i_wmask);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    o_rdata <= mem_q[i_raddr];
  end
endmodule

// ---- hw/stlb_top.sv ----
// Split instruction and data translation buffers with shadowed segment registers.
// Assumes synchronous requests from fetch/load-store logic; the table walk is outside.
//
// Notes on behaviour
// - separate 128-entry, 2-way, 64-set buffers
// - two segment copies, both written together
// - read both ways; valid tag match hits
// - miss searches, out-of-order miss deferred
// - refill chosen way, retry must hit
// - entry keeps EA bits 10-13 index
// - one replacement bit per set, updated on every hit
// - refill prefers invalid way
// - both lookups per cycle, one exception
// - miss exceptions: pipe empty, ready retire
// - EA0-EA3 pick segment register
// - set index EA14-19, compare 34 bits
// - protection check, then changed-bit search
// - hit passes page number and attributes
// - reset disables translation, keeps valid bits
// - invalidate clears four entries at index
// - no invalidate broadcast or snoop
// - sync stalls while hold input asserted
// - invalidate-all raises illegal instruction
// - invalidate leaves prefetch buffer alone
`timescale 1ns/1ps
module stlb_top
  import stlb_pkg::*;
#(
  parameter int SETS = STLB_SETS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_xlate_on,
  input wire logic i_xlate_off,
  input wire logic i_sr_we,
  input wire logic [3:0] i_sr_idx,
  input wire logic [STLB_VIRTUAL_SEGMENT_ID_W-1:0] i_sr_virtual_segment_id,
  input wire logic i_ireq,
  input wire logic [STLB_EA_W-1:0] i_iea,
  input wire logic i_dreq,
  input wire logic [STLB_EA_W-1:0] i_dea,
  input wire logic i_dstore,
  input wire logic i_dooo,
  input wire logic i_user,
  input wire logic i_pipe_empty,
  input wire logic i_dready_retire,
  input wire logic i_refill_we,
  input wire logic i_refill_dside,
  input wire logic [STLB_EA_W-1:0] i_refill_ea,
  input wire logic [STLB_VIRTUAL_SEGMENT_ID_W-1:0] i_refill_virtual_segment_id,
  input wire logic [STLB_RPN_W-1:0] i_refill_rpn,
  input wire logic [STLB_ATTR_W-1:0] i_refill_attr,
  input wire logic [STLB_PP_W-1:0] i_refill_pp,
  input wire logic i_refill_c,
  input wire logic i_inval,
  input wire logic [STLB_EA_W-1:0] i_inval_ea,
  input wire logic i_inval_all_op,
  input wire logic i_sync_op,
  input wire logic i_sync_hold,
  output logic o_xlate_en,
  output logic o_ihit,
  output logic [STLB_RPN_W-1:0] o_irpn,
  output logic [STLB_ATTR_W-1:0] o_iattr,
  output logic o_dhit,
  output logic [STLB_RPN_W-1:0] o_drpn,
  output logic [STLB_ATTR_W-1:0] o_dattr,
  output logic o_isearch,
  output logic o_dsearch,
  output logic o_dchg_search,
  output logic o_iprot_err,
  output logic o_dprot_err,
  output logic [2:0] o_exc,
  output logic o_illegal_op,
  output logic o_stall
);
  localparam int MW = 2 * STLB_ENT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Translation enable and synchronised hold
  logic xlate_q;
  logic hold_meta_q;
  logic hold_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      xlate_q <= STLB_XLATE_RST;
    end else if (i_xlate_on) begin
      xlate_q <= 1'b1;
    end else if (i_xlate_off) begin
      xlate_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hold_meta_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      hold_meta_q <= i_sync_hold;
      hold_q <= hold_meta_q;
    end
  end

  // Sync stalls only while the hold is seen asserted
  logic sync_wait_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync_wait_q <= 1'b0;
    end else if (i_sync_op) begin
      sync_wait_q <= 1'b1;
    end else if (!hold_q) begin
      sync_wait_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_stall <= 1'b0;
    end else begin
      o_stall <= (sync_wait_q | i_sync_op) & hold_q;
    end
  end

  // Invalidate-all is not supported
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_illegal_op <= 1'b0;
    end else begin
      o_illegal_op <= i_inval_all_op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadowed segment registers, one copy per unit
  logic [STLB_VIRTUAL_SEGMENT_ID_W-1:0] isr_q [STLB_SEG_N];
  logic [STLB_VIRTUAL_SEGMENT_ID_W-1:0] dsr_q [STLB_SEG_N];

  // No valid bit: software must load them before enabling translation
  always_ff @(posedge i_clk_sys) begin
    if (i_sr_we) begin
      isr_q[i_sr_idx] <= i_sr_virtual_segment_id;
      dsr_q[i_sr_idx] <= i_sr_virtual_segment_id;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lookup stage 0: index arrays, segment lookup in parallel
  logic [STLB_IDX_W-1:0] iidx;
  logic [STLB_IDX_W-1:0] didx;
  logic [STLB_IDX_W-1:0] ridx;
  logic [STLB_IDX_W-1:0] vidx;
  assign iidx = i_iea[STLB_IDX_LSB +: STLB_IDX_W];
  assign didx = i_dea[STLB_IDX_LSB +: STLB_IDX_W];
  assign ridx = i_refill_ea[STLB_IDX_LSB +: STLB_IDX_W];
  assign vidx = i_inval_ea[STLB_IDX_LSB +: STLB_IDX_W];

  logic ireq_q, dreq_q, dstore_q, dooo_q, user_q;
  logic [STLB_VIRTUAL_SEGMENT_ID_W-1:0] ivsid_q, dvsid_q;
  logic [STLB_API_W+STLB_EPI_W-1:0] ipg_q, dpg_q;
  logic [STLB_IDX_W-1:0] iidx_q, didx_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ireq_q <= 1'b0;
      dreq_q <= 1'b0;
    end else begin
      ireq_q <= i_ireq & xlate_q;
      dreq_q <= i_dreq & xlate_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    ivsid_q <= isr_q[i_iea[STLB_SR_LSB +: 4]];
    dvsid_q <= dsr_q[i_dea[STLB_SR_LSB +: 4]];
    ipg_q <= i_iea[STLB_EPI_LSB +: STLB_API_W + STLB_EPI_W];
    dpg_q <= i_dea[STLB_EPI_LSB +: STLB_API_W + STLB_EPI_W];
    iidx_q <= iidx;
    didx_q <= didx;
    dstore_q <= i_dstore;
    dooo_q <= i_dooo;
    user_q <= i_user;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry arrays and write ports (refill and invalidate)
  logic [MW-1:0] irow, drow;
  logic [SETS-1:0] ilru_q, dlru_q;
  logic [STLB_ENT_W-1:0] rent;
  logic [MW-1:0] iwdata, dwdata, iwmask, dwmask;
  logic iwe, dwe;
  logic [STLB_IDX_W-1:0] iwaddr, dwaddr;
  logic [STLB_ENT_W-1:0] vmask;
  logic [STLB_ENT_W-1:0] fmask;
  logic rway;
  logic [1:0] rvalid;

  assign rent = {1'b1, i_refill_virtual_segment_id, i_refill_ea[STLB_EPI_LSB +: STLB_API_W + STLB_EPI_W],
                 i_refill_rpn, i_refill_attr, i_refill_pp, i_refill_c};
  assign vmask = {1'b1, {(STLB_ENT_W-1){1'b0}}};
  assign fmask = {STLB_ENT_W{1'b1}};
  // Way valid bits come from the valid shadow below; array itself is not reset
  logic [1:0] ival_q [SETS];
  logic [1:0] dval_q [SETS];
  assign rvalid = i_refill_dside ? dval_q[ridx] : ival_q[ridx];
  // Invalid way first, else least recently used way
  assign rway = (!rvalid[0]) ? 1'b0 : (!rvalid[1]) ? 1'b1 :
                (i_refill_dside ? dlru_q[ridx] : ilru_q[ridx]);

  // Invalidate wins the port; a refill in the same cycle is dropped
  always_comb begin
    iwe = i_inval | (i_refill_we & !i_refill_dside);
    dwe = i_inval | (i_refill_we & i_refill_dside);
    iwaddr = i_inval ? vidx : ridx;
    dwaddr = iwaddr;
    iwdata = i_inval ? '0 : (rway ? {rent, {STLB_ENT_W{1'b0}}} : {{STLB_ENT_W{1'b0}}, rent});
    dwdata = iwdata;
    iwmask = i_inval ? {vmask, vmask} : (rway ? {fmask, {STLB_ENT_W{1'b0}}} : {{STLB_ENT_W{1'b0}}, fmask});
    dwmask = iwmask;
  end

  stlb_mem #(.DEPTH(SETS), .AW(STLB_IDX_W), .W(MW)) u_imem (
    .i_clk_sys(i_clk_sys),
    .i_raddr(iidx),
    .o_rdata(irow),
    .i_we(iwe),
    .i_waddr(iwaddr),
    .i_wdata(iwdata),
    .i_wmask(iwmask)
  );

  stlb_mem #(.DEPTH(SETS), .AW(STLB_IDX_W), .W(MW)) u_dmem (
    .i_clk_sys(i_clk_sys),
    .i_raddr(didx),
    .o_rdata(drow),
    .i_we(dwe),
    .i_waddr(dwaddr),
    .i_wdata(dwdata),
    .i_wmask(dwmask)
  );

  // Valid shadow for replacement choice; also unreset to keep entries
  always_ff @(posedge i_clk_sys) begin
    if (i_inval) begin
      ival_q[vidx] <= 2'h0;
      dval_q[vidx] <= 2'h0;
    end else if (i_refill_we) begin
      if (i_refill_dside) begin
        dval_q[ridx][rway] <= 1'b1;
      end else begin
        ival_q[ridx][rway] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare stage
  logic [1:0] ihitw, dhitw;
  logic [STLB_TAG_W-1:0] itag, dtag;
  assign itag = {ivsid_q, ipg_q};
  assign dtag = {dvsid_q, dpg_q};

  genvar w;
  generate
    for (w = 0; w < STLB_WAYS; w++) begin : g_way
      assign ihitw[w] = irow[w*STLB_ENT_W + STLB_E_V] &
                        (irow[w*STLB_ENT_W + STLB_E_TAG +: STLB_TAG_W] == itag);
      assign dhitw[w] = drow[w*STLB_ENT_W + STLB_E_V] &
                        (drow[w*STLB_ENT_W + STLB_E_TAG +: STLB_TAG_W] == dtag);
    end
  endgenerate

  logic [STLB_ENT_W-1:0] ient, dent;
  logic ihit, dhit, iprot, dprot, dchg;
  assign ient = ihitw[1] ? irow[STLB_ENT_W +: STLB_ENT_W] : irow[0 +: STLB_ENT_W];
  assign dent = dhitw[1] ? drow[STLB_ENT_W +: STLB_ENT_W] : drow[0 +: STLB_ENT_W];
  assign ihit = ireq_q & |ihitw;
  assign dhit = dreq_q & |dhitw;
  // Key 1 applies to problem state; pp=00 denies user, pp=11 is read-only
  function automatic logic prot_err(input logic [1:0] pp, input logic user, input logic wr);
    prot_err = (user & (pp == 2'h0)) | (wr & ((pp == 2'h3) | (user & (pp == 2'h1))));
  endfunction
  assign iprot = ihit & prot_err(ient[STLB_E_PP +: STLB_PP_W], user_q, 1'b0);
  assign dprot = dhit & prot_err(dent[STLB_E_PP +: STLB_PP_W], user_q, dstore_q);
  assign dchg = dhit & !dprot & dstore_q & !dent[STLB_E_C] & !dooo_q;

  // Replacement bit points at the other way after any use, speculative too
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ilru_q <= '0;
      dlru_q <= '0;
    end else begin
      if (ihit) begin
        ilru_q[iidx_q] <= ~ihitw[1];
      end
      if (dhit) begin
        dlru_q[didx_q] <= ~dhitw[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_ihit <= 1'b0;
      o_dhit <= 1'b0;
      o_irpn <= '0;
      o_iattr <= '0;
      o_drpn <= '0;
      o_dattr <= '0;
      o_iprot_err <= 1'b0;
      o_dprot_err <= 1'b0;
      o_dchg_search <= 1'b0;
      o_isearch <= 1'b0;
      o_dsearch <= 1'b0;
    end else begin
      o_ihit <= ihit & !iprot;
      o_dhit <= dhit & !dprot & !dchg;
      o_irpn <= ient[STLB_E_RPN +: STLB_RPN_W];
      o_iattr <= ient[STLB_E_ATTR +: STLB_ATTR_W];
      o_drpn <= dent[STLB_E_RPN +: STLB_RPN_W];
      o_dattr <= dent[STLB_E_ATTR +: STLB_ATTR_W];
      o_iprot_err <= iprot;
      o_dprot_err <= dprot;
      o_dchg_search <= dchg;
      o_isearch <= ireq_q & !(|ihitw);
      // Out-of-order misses wait until reissued in order
      o_dsearch <= dreq_q & !(|dhitw) & !dooo_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Miss exception reporting, one at a time
  logic imiss_pend_q, dmiss_pend_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      imiss_pend_q <= 1'b0;
      dmiss_pend_q <= 1'b0;
    end else begin
      // Walker reports a failed search by refilling nothing; the miss stays pending
      imiss_pend_q <= (imiss_pend_q & !(o_exc == STLB_EXC_IMISS)) | (ireq_q & !(|ihitw));
      dmiss_pend_q <= (dmiss_pend_q & !(o_exc == STLB_EXC_DMISS)) | (dreq_q & !(|dhitw) & !dooo_q);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_exc <= STLB_EXC_NONE;
    end else if (dmiss_pend_q & i_dready_retire & !(o_exc == STLB_EXC_DMISS)) begin
      o_exc <= STLB_EXC_DMISS;
    end else if (imiss_pend_q & i_pipe_empty & !(o_exc == STLB_EXC_IMISS)) begin
      o_exc <= STLB_EXC_IMISS;
    end else begin
      o_exc <= STLB_EXC_NONE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_xlate_en <= 1'b0;
    end else begin
      o_xlate_en <= xlate_q;
    end
  end
  // Invalidates are local only; no snoop port exists
  // Invalidate touches only the arrays, never fetch state
endmodule

// ---- verification/stlb_walk_model.sv ----
// Table-search stand-in: answers every miss search with a refill of the looked-up page.
// Assumes one search in flight at a time; entry fields are derived from the effective address.
`timescale 1ns/1ps
module stlb_walk_model
  import stlb_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [3:0] i_delay,
  input wire logic i_ireq,
  input wire logic [STLB_EA_W-1:0] i_iea,
  input wire logic i_dreq,
  input wire logic [STLB_EA_W-1:0] i_dea,
  input wire logic i_isearch,
  input wire logic i_dsearch,
  output logic o_refill_we,
  output logic o_refill_dside,
  output logic [STLB_EA_W-1:0] o_refill_ea,
  output logic [STLB_VIRTUAL_SEGMENT_ID_W-1:0] o_refill_virtual_segment_id,
  output logic [STLB_RPN_W-1:0] o_refill_rpn,
  output logic [STLB_ATTR_W-1:0] o_refill_attr,
  output logic [STLB_PP_W-1:0] o_refill_pp,
  output logic o_refill_c
);
  logic [STLB_EA_W-1:0] last_i = 32'h0, last_d = 32'h0, ea;
  always @(posedge i_clk_sys) begin
    if (i_ireq) last_i <= i_iea;
    if (i_dreq) last_d <= i_dea;
  end
  ////////////////////////////////////////////////////////////////
  task automatic put(input logic [STLB_EA_W-1:0] a);
    o_refill_ea = a;
    o_refill_virtual_segment_id = {20'hABCDE, a[31:28]};
    o_refill_rpn = a[31:12] ^ 20'h5A5A5;
    o_refill_attr = a[7:4];
    o_refill_pp = a[1:0];
    o_refill_c = a[2];
  endtask
  initial begin
    o_refill_we = 1'b0;
    o_refill_dside = 1'b0;
    put(32'h0);
    forever begin
      @(posedge i_clk_sys);
      if (i_isearch === 1'b1 || i_dsearch === 1'b1) begin
        o_refill_dside <= i_dsearch;
        ea = i_dsearch ? last_d : last_i;
        repeat (i_delay) @(negedge i_clk_sys);
        put(ea);
        o_refill_we = 1'b1;
        @(negedge i_clk_sys);
        o_refill_we = 1'b0;
        // Released lines flip so a stale value never looks valid
        put(~ea);
      end
    end
  end
endmodule

// ---- verification/stlb_sva.sv ----
// Port-level checks for the split translation buffers.
// Assumes bind to stlb_top; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module stlb_sva
  import stlb_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_xlate_on,
  input wire logic i_xlate_off,
  input wire logic i_dreq,
  input wire logic i_ireq,
  input wire logic i_dstore,
  input wire logic i_dooo,
  input wire logic i_pipe_empty,
  input wire logic i_dready_retire,
  input wire logic i_inval_all_op,
  input wire logic i_sync_hold,
  input wire logic o_xlate_en,
  input wire logic o_ihit,
  input wire logic o_dhit,
  input wire logic o_dsearch,
  input wire logic o_dchg_search,
  input wire logic o_dprot_err,
  input wire logic [2:0] o_exc,
  input wire logic o_illegal_op,
  input wire logic o_stall
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////
  sequence s_ooo_req;
    i_dreq && i_dooo;
  endsequence
  sequence s_hold_low;
    !i_sync_hold [*4];
  endsequence
  property p_illegal; i_inval_all_op |=> o_illegal_op; endproperty
  a_illegal: assert property (p_illegal) else $error("invalidate-all not flagged");
  property p_xon; i_xlate_on |-> ##2 o_xlate_en; endproperty
  a_xon: assert property (p_xon) else $error("enable not set");
  property p_xoff; i_xlate_off && !i_xlate_on |-> ##2 !o_xlate_en; endproperty
  a_xoff: assert property (p_xoff) else $error("enable not cleared");
  property p_onehot; $onehot(o_exc); endproperty
  a_onehot: assert property (p_onehot) else $error("more than one exception");
  property p_dmiss; o_exc == STLB_EXC_DMISS |-> $past(i_dready_retire); endproperty
  a_dmiss: assert property (p_dmiss) else $error("data miss reported early");
  property p_imiss; o_exc == STLB_EXC_IMISS |-> $past(i_pipe_empty); endproperty
  a_imiss: assert property (p_imiss) else $error("fetch miss reported early");
  property p_dhit; o_dhit |-> $past(i_dreq, 2); endproperty
  a_dhit: assert property (p_dhit) else $error("data hit without lookup");
  property p_ihit; o_ihit |-> $past(i_ireq, 2); endproperty
  a_ihit: assert property (p_ihit) else $error("fetch hit without lookup");
  property p_ooo; s_ooo_req |-> ##2 !o_dsearch; endproperty
  a_ooo: assert property (p_ooo) else $error("search for out-of-order access");
  property p_excl; o_dhit |-> !o_dsearch && !o_dprot_err && !o_dchg_search; endproperty
  a_excl: assert property (p_excl) else $error("hit with fault");
  property p_chg; o_dchg_search |-> $past(i_dreq, 2) && $past(i_dstore, 2); endproperty
  a_chg: assert property (p_chg) else $error("changed search without store");
  property p_stall; s_hold_low |=> !o_stall; endproperty
  a_stall: assert property (p_stall) else $error("stall after hold dropped");
endmodule

// ---- verification/tb_top.sv ----
// Directed bench for the split translation buffers with a table-search stand-in.
// Assumes the walk model owns the refill port; all other inputs are driven here.
`timescale 1ns/1ps
module tb_top;
  import stlb_pkg::*;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_xlate_on = 1'b0, i_xlate_off = 1'b0, i_sr_we = 1'b0;
  logic i_ireq = 1'b0, i_dreq = 1'b0, i_dstore = 1'b0, i_dooo = 1'b0, i_user = 1'b0, i_pipe_empty = 1'b0;
  logic i_dready_retire = 1'b0, i_inval = 1'b0, i_inval_all_op = 1'b0, i_sync_op = 1'b0, i_sync_hold = 1'b0;
  logic [3:0] i_sr_idx = 4'h0, dly = 4'h1;
  logic [STLB_VIRTUAL_SEGMENT_ID_W-1:0] i_sr_virtual_segment_id = 24'h000000, i_refill_virtual_segment_id;
  logic [STLB_EA_W-1:0] i_iea = 32'h0, i_dea = 32'h0, i_inval_ea = 32'h0, i_refill_ea, ea, a, b, c, ep;
  logic i_refill_we, i_refill_dside, i_refill_c, o_xlate_en, o_ihit, o_dhit, o_isearch, o_dsearch;
  logic o_dchg_search, o_iprot_err, o_dprot_err, o_illegal_op, o_stall, r_hit, r_srch, r_prot, r_chg;
  logic [STLB_RPN_W-1:0] i_refill_rpn, o_irpn, o_drpn, r_rpn;
  logic [STLB_ATTR_W-1:0] i_refill_attr, o_iattr, o_dattr, r_attr;
  logic [STLB_PP_W-1:0] i_refill_pp;
  logic [2:0] o_exc;
  int miscompares = 0, checks_done = 0;
  initial forever #25 i_clk_sys = ~i_clk_sys;
  stlb_top dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_xlate_on(i_xlate_on), .i_xlate_off(i_xlate_off),
    .i_sr_we(i_sr_we), .i_sr_idx(i_sr_idx), .i_sr_virtual_segment_id(i_sr_virtual_segment_id), .i_ireq(i_ireq), .i_iea(i_iea),
    .i_dreq(i_dreq), .i_dea(i_dea), .i_dstore(i_dstore), .i_dooo(i_dooo), .i_user(i_user),
    .i_pipe_empty(i_pipe_empty), .i_dready_retire(i_dready_retire), .i_refill_we(i_refill_we),
    .i_refill_dside(i_refill_dside), .i_refill_ea(i_refill_ea), .i_refill_virtual_segment_id(i_refill_virtual_segment_id),
    .i_refill_rpn(i_refill_rpn), .i_refill_attr(i_refill_attr), .i_refill_pp(i_refill_pp),
    .i_refill_c(i_refill_c), .i_inval(i_inval), .i_inval_ea(i_inval_ea), .i_inval_all_op(i_inval_all_op),
    .i_sync_op(i_sync_op), .i_sync_hold(i_sync_hold), .o_xlate_en(o_xlate_en), .o_ihit(o_ihit),
    .o_irpn(o_irpn), .o_iattr(o_iattr), .o_dhit(o_dhit), .o_drpn(o_drpn), .o_dattr(o_dattr),
    .o_isearch(o_isearch), .o_dsearch(o_dsearch), .o_dchg_search(o_dchg_search), .o_iprot_err(o_iprot_err),
    .o_dprot_err(o_dprot_err), .o_exc(o_exc), .o_illegal_op(o_illegal_op), .o_stall(o_stall));
  stlb_walk_model walk (.i_clk_sys(i_clk_sys), .i_delay(dly), .i_ireq(i_ireq), .i_iea(i_iea), .i_dreq(i_dreq),
    .i_dea(i_dea), .i_isearch(o_isearch), .i_dsearch(o_dsearch), .o_refill_we(i_refill_we),
    .o_refill_dside(i_refill_dside), .o_refill_ea(i_refill_ea), .o_refill_virtual_segment_id(i_refill_virtual_segment_id),
    .o_refill_rpn(i_refill_rpn), .o_refill_attr(i_refill_attr), .o_refill_pp(i_refill_pp),
    .o_refill_c(i_refill_c));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mk(input logic [3:0] sr, input logic [5:0] abbreviated_page_index, input logic [3:0] extended_page_index,
                                     input logic [5:0] idx, input logic [11:0] off);
    mk = {sr, abbreviated_page_index, extended_page_index, idx, off};
  endfunction
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic tend(input string name);
    $display("test %s done", name);
  endtask
  task automatic wr_sr(input logic [3:0] k, input logic [23:0] v);
    @(negedge i_clk_sys);
    i_sr_we = 1'b1;
    i_sr_idx = k;
    i_sr_virtual_segment_id = v;
    @(negedge i_clk_sys);
    i_sr_we = 1'b0;
  endtask
  task automatic inval(input logic [5:0] idx);
    @(negedge i_clk_sys);
    i_inval = 1'b1;
    i_inval_ea = {14'h0, idx, 12'h0};
    @(negedge i_clk_sys);
    i_inval = 1'b0;
  endtask
  // Results are ORed over three cycles so a one-cycle answer is never missed
  task automatic look(input logic d, input logic [31:0] x, input logic st, input logic usr, input logic ooo);
    @(negedge i_clk_sys);
    if (d) i_dreq = 1'b1;
    else i_ireq = 1'b1;
    if (d) i_dea = x;
    else i_iea = x;
    i_dstore = st;
    i_user = usr;
    i_dooo = ooo;
    {r_hit, r_srch, r_prot, r_chg} = 4'h0;
    @(negedge i_clk_sys);
    {i_ireq, i_dreq} = 2'h0;
    i_dea = ~i_dea;
    i_iea = ~i_iea;
    repeat (3) begin
      @(negedge i_clk_sys);
      if ((d ? o_dhit : o_ihit) === 1'b1) {r_hit, r_rpn, r_attr} = d ? {1'b1, o_drpn, o_dattr} : {1'b1, o_irpn, o_iattr};
      r_srch = r_srch | (d ? o_dsearch : o_isearch);
      r_prot = r_prot | (d ? o_dprot_err : o_iprot_err);
      r_chg = r_chg | o_dchg_search;
    end
    repeat (6) @(negedge i_clk_sys);
  endtask
  task automatic miss(input logic d, input logic [31:0] x);
    look(d, x, 1'b0, 1'b0, 1'b0);
    chk(r_srch === 1'b1 && r_hit === 1'b0, "expected miss search");
  endtask
  task automatic hit(input logic d, input logic [31:0] x);
    look(d, x, 1'b0, 1'b0, 1'b0);
    chk(r_hit === 1'b1 && r_srch === 1'b0 && r_rpn === (x[31:12] ^ 20'h5A5A5) && r_attr === x[7:4], "bad hit");
  endtask
  task automatic wait_exc(input logic [2:0] e);
    logic got;
    got = 1'b0;
    repeat (8) begin
      @(negedge i_clk_sys);
      if (o_exc === e) got = 1'b1;
    end
    chk(got, "exception not reported");
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) begin
      @(negedge i_clk_sys);
      chk(o_exc === STLB_EXC_NONE && o_xlate_en === 1'b0, "reset outputs");
    end
    i_rst = 1'b0;
    for (int k = 0; k < 16; k++) wr_sr(k[3:0], {20'hABCDE, k[3:0]});
    for (int k = 0; k < 64; k++) inval(k[5:0]);
    @(negedge i_clk_sys);
    i_xlate_on = 1'b1;
    @(negedge i_clk_sys);
    i_xlate_on = 1'b0;
    @(negedge i_clk_sys);
    chk(o_xlate_en === 1'b1, "enable");
    tend("init");
    ea = mk(4'h1, 6'h11, 4'h3, 6'h05, 12'h0A6);
    miss(1'b0, ea);
    hit(1'b0, ea);
    miss(1'b1, ea);
    hit(1'b1, ea);
    miss(1'b1, mk(4'h1, 6'h11, 4'hC, 6'h05, 12'h0A6));
    tend("fill");
    ea = mk(4'h2, 6'h07, 4'h3, 6'h09, 12'h0A6);
    look(1'b1, ea, 1'b0, 1'b0, 1'b1);
    chk(r_srch === 1'b0 && r_hit === 1'b0, "out-of-order search");
    dly = 4'h3;
    miss(1'b1, ea);
    hit(1'b1, ea);
    dly = 4'h1;
    i_dready_retire = 1'b1;
    wait_exc(STLB_EXC_DMISS);
    i_dready_retire = 1'b0;
    i_pipe_empty = 1'b1;
    wait_exc(STLB_EXC_IMISS);
    i_pipe_empty = 1'b0;
    tend("exceptions");
    a = mk(4'h3, 6'h01, 4'h3, 6'h20, 12'h0A6);
    b = mk(4'h3, 6'h02, 4'h3, 6'h20, 12'h0A6);
    c = mk(4'h3, 6'h03, 4'h3, 6'h20, 12'h0A6);
    miss(1'b1, a);
    miss(1'b1, b);
    hit(1'b1, a);
    hit(1'b1, b);
    hit(1'b1, a);
    miss(1'b1, c);
    hit(1'b1, a);
    miss(1'b1, b);
    tend("replace");
    inval(6'h05);
    miss(1'b0, mk(4'h1, 6'h11, 4'h3, 6'h05, 12'h0A6));
    miss(1'b1, mk(4'h1, 6'h11, 4'h3, 6'h05, 12'h0A6));
    hit(1'b1, a);
    miss(1'b0, a);
    hit(1'b0, a);
    wr_sr(4'h3, 24'h000777);
    miss(1'b0, a);
    miss(1'b1, a);
    tend("invalidate");
    ep = mk(4'h4, 6'h05, 4'h3, 6'h0A, 12'h0A4);
    miss(1'b1, ep);
    look(1'b1, ep, 1'b0, 1'b1, 1'b0);
    chk(r_prot === 1'b1 && r_hit === 1'b0, "protection");
    hit(1'b1, ep);
    miss(1'b0, ep);
    look(1'b0, ep, 1'b0, 1'b1, 1'b0);
    chk(r_prot === 1'b1 && r_hit === 1'b0, "fetch protection");
    ea = mk(4'h4, 6'h06, 4'h3, 6'h0B, 12'h0A2);
    miss(1'b1, ea);
    look(1'b1, ea, 1'b1, 1'b0, 1'b0);
    chk(r_chg === 1'b1 && r_hit === 1'b0, "changed search");
    hit(1'b1, ea);
    tend("protect");
    @(negedge i_clk_sys);
    i_inval_all_op = 1'b1;
    @(negedge i_clk_sys);
    i_inval_all_op = 1'b0;
    chk(o_illegal_op === 1'b1, "illegal op");
    i_sync_hold = 1'b1;
    @(negedge i_clk_sys);
    i_sync_op = 1'b1;
    @(negedge i_clk_sys);
    i_sync_op = 1'b0;
    repeat (5) @(negedge i_clk_sys);
    chk(o_stall === 1'b1, "no stall");
    i_sync_hold = 1'b0;
    repeat (5) @(negedge i_clk_sys);
    chk(o_stall === 1'b0, "stall stuck");
    tend("sync");
    @(negedge i_clk_sys);
    i_xlate_off = 1'b1;
    @(negedge i_clk_sys);
    i_xlate_off = 1'b0;
    look(1'b1, ep, 1'b0, 1'b0, 1'b0);
    chk(o_xlate_en === 1'b0 && r_hit === 1'b0 && r_srch === 1'b0, "lookup while disabled");
    i_rst = 1'b1;
    repeat (20) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk(o_xlate_en === 1'b0, "enable after reset");
    i_xlate_on = 1'b1;
    @(negedge i_clk_sys);
    i_xlate_on = 1'b0;
    hit(1'b1, ep);
    tend("reset");
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    miscompares++;
    wrap_up;
  end
endmodule
bind stlb_top stlb_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_xlate_on(i_xlate_on),
  .i_xlate_off(i_xlate_off), .i_dreq(i_dreq), .i_ireq(i_ireq), .i_dstore(i_dstore), .i_dooo(i_dooo),
  .i_pipe_empty(i_pipe_empty), .i_dready_retire(i_dready_retire), .i_inval_all_op(i_inval_all_op),
  .i_sync_hold(i_sync_hold), .o_xlate_en(o_xlate_en), .o_ihit(o_ihit), .o_dhit(o_dhit), .o_dsearch(o_dsearch),
  .o_dchg_search(o_dchg_search), .o_dprot_err(o_dprot_err), .o_exc(o_exc), .o_illegal_op(o_illegal_op),
  .o_stall(o_stall));
